//--- async_serial_rx.sv
// async serial receiver with status flags, fifo, interrupt and dma request
// Functional notes
// - codes 0..6 divide system clock by 2^code
// - code 7 takes clock from external pin
// - fifo write sets ready flag, raises request
// - ready and interrupt persist until fifo empty
// - any error flag blocks dma request
// - inhibit bit 7 blocks receive interrupt
`timescale 1ns/100ps
module async_serial_rx
  import serial_rx_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // serial line and clock pin
  input  wire logic        i_rxd,
  input  wire logic        i_external_serial_clock_pin,
  // dma handshake
  output logic             o_rx_dma_req,
  input  wire logic        i_rx_dma_ack,
  // interrupts
  output logic             o_rx_irq,
  output logic             o_irq
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_t;

  rx_state_t   state_r;
  rx_state_t   state_nxt;
  logic [7:0]  async_control_b_r;
  logic [3:0]  int_st_r;
  logic [3:0]  int_msk_r;
  logic        parity_error_flag_r;
  logic        framing_error_flag_r;
  logic        overrun_flag_r;
  logic [7:0]  fifo_mem [FIFO_DEPTH];
  logic [FIFO_AW:0] wr_ptr_r;
  logic [FIFO_AW:0] rd_ptr_r;
  logic [3:0]  ovs_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic        par_acc_r;
  logic        rxd_q1_r;
  logic        rxd_q2_r;
  logic        ap_valid_r;
  logic        ap_write_r;
  logic [7:0]  ap_addr_r;
  logic [31:0] hrdata_r;

  // status decode
  logic        tick;
  logic        fifo_empty;
  logic        fifo_full;
  logic        receive_data_ready_flag;
  logic        any_error;
  logic        char_done;
  logic        push;
  logic        overrun_evt;
  logic        frame_err_evt;
  logic        par_err_evt;
  logic        sw_read_data;
  logic        dma_pop;
  logic        pop;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_int_st;
  logic        wr_int_msk;
  logic        addr_phase;
  logic [31:0] rd_mux;
  logic [3:0]  evt_vec;
  logic [FIFO_AW:0] fill_cnt;

  // serial clock selection
  serial_clk_sel u_clk_sel (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_div_sel (async_control_b_r[DIV_SEL_LSB +: DIV_SEL_W]),
    .i_ext_clk (i_external_serial_clock_pin),
    .o_tick    (tick)
  );

  // fifo and flag decode
  assign fifo_empty = (wr_ptr_r == rd_ptr_r);
  assign fill_cnt   = wr_ptr_r - rd_ptr_r;                           // wraps with the pointers
  assign fifo_full  = (wr_ptr_r[FIFO_AW-1:0] == rd_ptr_r[FIFO_AW-1:0]) &&
                      (wr_ptr_r[FIFO_AW] != rd_ptr_r[FIFO_AW]);
  assign receive_data_ready_flag = !fifo_empty;
  assign any_error  = parity_error_flag_r | framing_error_flag_r | overrun_flag_r;
  assign char_done  = tick && (ovs_r == OVS_MID) && (state_r == ST_STOP);
  assign frame_err_evt = char_done && !rxd_q2_r;
  assign par_err_evt   = char_done && par_acc_r;
  assign push        = char_done && !fifo_full;
  assign overrun_evt = char_done && fifo_full;

  // ahb-lite decode
  assign addr_phase   = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
  assign wr_ctrl      = ap_valid_r && ap_write_r && (ap_addr_r == CTRL_OFF);
  assign wr_status    = ap_valid_r && ap_write_r && (ap_addr_r == STATUS_OFF);
  assign wr_int_st    = ap_valid_r && ap_write_r && (ap_addr_r == INT_ST_OFF);
  assign wr_int_msk   = ap_valid_r && ap_write_r && (ap_addr_r == INT_MSK_OFF);
  assign sw_read_data = addr_phase && !i_hwrite && (i_haddr == DATA_OFF);
  assign dma_pop      = i_rx_dma_ack && o_rx_dma_req;
  assign pop          = (sw_read_data || dma_pop) && !fifo_empty;
  assign o_hreadyout  = 1'b1;
  assign o_hresp      = 1'b0;
  assign o_hrdata     = hrdata_r;

  // read mux; status shows flags, data pops the fifo head
  assign rd_mux =
    (i_haddr == CTRL_OFF)    ? {24'h000000, async_control_b_r} :
    (i_haddr == STATUS_OFF)  ? {28'h0000000, overrun_flag_r, framing_error_flag_r,
                                parity_error_flag_r, receive_data_ready_flag} :
    (i_haddr == DATA_OFF)    ? {24'h000000, fifo_mem[rd_ptr_r[FIFO_AW-1:0]]} :
    (i_haddr == INT_ST_OFF)  ? {28'h0000000, int_st_r} :
    (i_haddr == INT_MSK_OFF) ? {28'h0000000, int_msk_r} : 32'h00000000;

  // requests: interrupt held while fifo not empty, dma blocked on errors
  assign o_rx_irq = receive_data_ready_flag && async_control_b_r[RIE_BIT] &&
                    !async_control_b_r[INHIBIT_BIT];
  assign o_rx_dma_req = receive_data_ready_flag && async_control_b_r[DMA_EN_BIT] &&
                        !any_error;
  assign evt_vec = {overrun_evt, frame_err_evt, par_err_evt, push};
  assign o_irq   = |(int_st_r & int_msk_r);

  // receive frame sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (async_control_b_r[RX_EN_BIT] && !rxd_q2_r) state_nxt = ST_START;
      ST_START: if (tick && ovs_r == OVS_MID) state_nxt = rxd_q2_r ? ST_IDLE : ST_DATA;
      ST_DATA:  if (tick && ovs_r == OVS_MID && bit_cnt_r == DATA_BITS) state_nxt = ST_STOP;
      ST_STOP:  if (char_done) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // line sampling, oversample and shift registers
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r   <= ST_IDLE;
      rxd_q1_r  <= 1'b1;
      rxd_q2_r  <= 1'b1;
      ovs_r     <= 4'h0;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      par_acc_r <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      rxd_q1_r <= i_rxd;
      rxd_q2_r <= rxd_q1_r;
      if (state_r == ST_IDLE)
      begin
        ovs_r     <= 4'h0;
        bit_cnt_r <= 4'h0;
        par_acc_r <= 1'b0;
      end
      else if (tick)
      begin
        ovs_r <= (ovs_r == OVS_LAST) ? 4'h0 : ovs_r + 4'h1;
        if (ovs_r == OVS_MID && state_r == ST_DATA && bit_cnt_r != DATA_BITS)
        begin
          shift_r   <= {rxd_q2_r, shift_r[7:1]};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        else if (ovs_r == OVS_MID && state_r == ST_DATA)
        begin
          par_acc_r <= ^{rxd_q2_r, shift_r};     // even parity check
        end
      end
    end
  end

  // fifo storage
  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      fifo_mem[wr_ptr_r[FIFO_AW-1:0]] <= shift_r;
  end

  // fifo pointers; a full fifo drops the new character
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // error flags: set wins over write-one clear
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      parity_error_flag_r  <= 1'b0;
      framing_error_flag_r <= 1'b0;
      overrun_flag_r       <= 1'b0;
    end
    else
    begin
      parity_error_flag_r  <= par_err_evt ||
                              (parity_error_flag_r && !(wr_status && i_hwdata[PAR_ERR_BIT]));
      framing_error_flag_r <= frame_err_evt ||
                              (framing_error_flag_r && !(wr_status && i_hwdata[FRM_ERR_BIT]));
      overrun_flag_r       <= overrun_evt ||
                              (overrun_flag_r && !(wr_status && i_hwdata[OVR_BIT]));
    end
  end

  // bus registers and sticky interrupt status
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ap_valid_r        <= 1'b0;
      ap_write_r        <= 1'b0;
      ap_addr_r         <= 8'h00;
      hrdata_r          <= 32'h00000000;
      async_control_b_r <= CTRL_RST;
      int_st_r          <= 4'h0;
      int_msk_r         <= 4'h0;
    end
    else
    begin
      ap_valid_r <= addr_phase;
      ap_write_r <= i_hwrite;
      ap_addr_r  <= i_haddr;
      if (addr_phase && !i_hwrite)
        hrdata_r <= rd_mux;
      if (wr_ctrl)
        async_control_b_r <= i_hwdata[7:0];
      if (wr_int_msk)
        int_msk_r <= i_hwdata[3:0];
      int_st_r <= evt_vec | (int_st_r & ~(wr_int_st ? i_hwdata[3:0] : 4'h0));
    end
  end

  // checks
  inhibit_irq_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    async_control_b_r[INHIBIT_BIT] |-> !o_rx_irq)
    else $error("receive interrupt raised while inhibited");
  err_dma_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    overrun_flag_r |-> !o_rx_dma_req)
    else $error("dma request with error flag set");
  push_ready_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    push |=> receive_data_ready_flag)
    else $error("ready flag not set after push");
  ready_hold_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    pop && (fill_cnt > 3'h1) |=> receive_data_ready_flag)
    else $error("ready flag lost with characters left");
  overrun_set_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    char_done && fifo_full && !pop |=> overrun_flag_r && $stable(wr_ptr_r))
    else $error("overrun not flagged or character stored");
  irq_persist_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_rx_irq && !wr_ctrl && !pop |=> o_rx_irq)
    else $error("receive interrupt dropped with fifo not empty");
  dma_err_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (parity_error_flag_r || framing_error_flag_r) |-> !o_rx_dma_req)
    else $error("dma request during line error");
  ext_clk_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (async_control_b_r[DIV_SEL_LSB +: DIV_SEL_W] == DIV_EXT) && tick && !wr_ctrl
    |-> ##1 !tick)
    else $error("external clock tick longer than one cycle");
  dma_ready_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_rx_dma_req |-> receive_data_ready_flag)
    else $error("dma request with empty fifo");
  irq_ready_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_rx_irq |-> receive_data_ready_flag)
    else $error("receive interrupt with empty fifo");
  fill_limit_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    int'(fill_cnt) <= FIFO_DEPTH)
    else $error("fifo fill beyond depth");
  ready_drop_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    pop && !push && (fill_cnt == 3'h1) |=> !receive_data_ready_flag)
    else $error("ready flag kept with fifo emptied");
endmodule

//--- async_serial_rx_tb.sv
// self-checking testbench for the async serial receiver
`timescale 1ns/100ps
module async_serial_rx_tb
  import serial_rx_pkg::*;
;
  typedef struct packed {logic [2:0] sel; logic [7:0] data;} row_t;

  logic        sys_clk = 1'b0;
  logic        rstn, hsel, hwrite, hreadyout, hresp, dma_req, dma_ack;
  logic        rx_irq, irq, go, bad_par, bad_stop, txd, busy;
  logic [7:0]  haddr, tx_byte;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] bit_cycles;
  logic [3:0]  ext_cnt = 4'h0;
  int          bad_count, n_checks;
  row_t        rows [8] = '{'{3'h0, 8'ha5}, '{3'h1, 8'h3c}, '{3'h2, 8'h01},
    '{3'h3, 8'h80}, '{3'h4, 8'hff}, '{3'h5, 8'h00}, '{3'h6, 8'h5a}, '{3'h7, 8'hc3}};

  // clock and external serial clock, one rising edge per 8 cycles
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ext_cnt <= ext_cnt + 4'h1;

  async_serial_rx u_async_serial_rx (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_rxd(txd), .i_external_serial_clock_pin(ext_cnt[2]),
    .o_rx_dma_req(dma_req), .i_rx_dma_ack(dma_ack), .o_rx_irq(rx_irq), .o_irq(irq));

  serial_tx_model u_serial_tx_model (.i_sys_clk(sys_clk), .i_go(go), .i_byte(tx_byte),
    .i_bit_cycles(bit_cycles), .i_bad_parity(bad_par), .i_bad_stop(bad_stop),
    .o_txd(txd), .o_busy(busy));

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one ahb-lite single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  // one frame from the remote transmitter
  task automatic send(input logic [7:0] b, input logic [15:0] n, input logic bp, bs);
    @(posedge sys_clk);
    tx_byte <= b;
    bit_cycles <= n;
    bad_par <= bp;
    bad_stop <= bs;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  endtask

  // one-cycle dma acknowledge
  task automatic ack;
    @(posedge sys_clk);
    dma_ack <= 1'b1;
    @(posedge sys_clk);
    dma_ack <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    report_and_stop;
  end

  // main sequence
  initial
  begin
    {rstn, hsel, hwrite, dma_ack, go, bad_par, bad_stop} = 7'h0;
    {haddr, tx_byte, htrans, hwdata, bad_count, n_checks} = '0;
    bit_cycles = 16'd16;
    repeat (20) @(posedge sys_clk);
    chk("requests in reset", 32'h0, {29'h0, rx_irq, irq, dma_req});
    chk("hresp", 32'h0, {31'h0, hresp});
    rstn <= 1'b1;
    bus(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RST}, rd);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    foreach (rows[i])
    begin
      bus(1'b1, CTRL_OFF, (1 << RX_EN_BIT) | rows[i].sel);
      send(rows[i].data, rows[i].sel == DIV_EXT ? 16'd128 : 16'd16 << rows[i].sel, 0, 0);
      bus(1'b0, STATUS_OFF, 32'h0);
      chk("ready", 32'h1, rd);
      bus(1'b0, DATA_OFF, 32'h0);
      chk("data", {24'h0, rows[i].data}, rd);
    end
    // interrupt, inhibit, fifo overrun
    bus(1'b1, CTRL_OFF, 32'h28);
    send(8'h11, 16'd16, 0, 0);
    chk("rx irq", 32'h1, {31'h0, rx_irq});
    bus(1'b1, CTRL_OFF, 32'ha8);
    @(negedge sys_clk);
    chk("inhibited irq", 32'h0, {31'h0, rx_irq});
    bus(1'b1, CTRL_OFF, 32'h38);
    for (int k = 1; k < 5; k++) send(8'h11 + k[7:0], 16'd16, 0, 0);
    bus(1'b0, STATUS_OFF, 32'h0);
    chk("overrun", 32'h9, rd);
    chk("dma req on overrun", 32'h0, {31'h0, dma_req});
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, DATA_OFF, 32'h0);
      chk("fifo data", 32'h11 + k, rd);
      chk("rx irq held", {31'h0, k < 3}, {31'h0, rx_irq});
      bus(1'b0, STATUS_OFF, 32'h0);
      chk("ready held", {28'h0, 3'h4, k < 3}, rd);
    end
    bus(1'b1, STATUS_OFF, 32'h8);
    bus(1'b0, INT_ST_OFF, 32'h0);
    chk("int status", 32'h9, rd);
    chk("masked irq", 32'h0, {31'h0, irq});
    bus(1'b1, INT_MSK_OFF, 32'h9);
    @(negedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, INT_ST_OFF, 32'h9);
    @(negedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // dma with inhibit set, then error flags
    bus(1'b1, CTRL_OFF, 32'hb8);
    send(8'h3c, 16'd16, 0, 0);
    chk("dma req", 32'h1, {31'h0, dma_req});
    chk("irq inhibited", 32'h0, {31'h0, rx_irq});
    ack;
    chk("dma drained", 32'h0, {31'h0, dma_req});
    send(8'h3d, 16'd16, 1, 0);
    chk("dma req on parity", 32'h0, {31'h0, dma_req});
    bus(1'b0, STATUS_OFF, 32'h0);
    chk("parity flag", 32'h3, rd);
    bus(1'b1, STATUS_OFF, 32'h2);
    @(negedge sys_clk);
    chk("dma req resumed", 32'h1, {31'h0, dma_req});
    ack;
    send(8'h3e, 16'd16, 0, 1);
    chk("dma req on framing", 32'h0, {31'h0, dma_req});
    bus(1'b0, STATUS_OFF, 32'h0);
    chk("framing flag", 32'h5, rd);
    // mid-run reset empties the fifo and drops every request
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("requests after reset", 32'h0, {29'h0, rx_irq, irq, dma_req});
    chk("hrdata in reset", 32'h0, hrdata);
    rstn <= 1'b1;
    bus(1'b0, STATUS_OFF, 32'h0);
    chk("status after reset", 32'h0, rd);
    bus(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl after reset", {24'h0, CTRL_RST}, rd);
    report_and_stop;
  end
endmodule

//--- serial_clk_sel.sv
// serial clock tick generator: power-of-two divider or external pin
`timescale 1ns/100ps
module serial_clk_sel
  import serial_rx_pkg::*;
(
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  // control
  input  wire logic [2:0] i_div_sel,
  input  wire logic       i_ext_clk,
  // tick out
  output logic            o_tick
);
  logic [5:0] div_cnt_r;
  logic [5:0] div_mask;
  logic       ext_q1_r;
  logic       ext_q2_r;
  logic       ext_q3_r;
  logic       int_tick;
  logic       ext_tick;

  // divide factor 2^sel minus one as a counter mask
  assign div_mask = 6'((7'h01 << i_div_sel) - 7'h01);
  assign int_tick = ((div_cnt_r & div_mask) == div_mask);
  assign ext_tick = ext_q2_r & ~ext_q3_r;                             // rising edge of pin
  assign o_tick   = (i_div_sel == DIV_EXT) ? ext_tick : int_tick;

  // free running divider and pin synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_cnt_r <= 6'h00;
      ext_q1_r  <= 1'b0;
      ext_q2_r  <= 1'b0;
      ext_q3_r  <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 6'h01;
      ext_q1_r  <= i_ext_clk;
      ext_q2_r  <= ext_q1_r;
      ext_q3_r  <= ext_q2_r;
    end
  end

  // selecting the pin, the tick follows its edges only
  ext_sel_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_div_sel == DIV_EXT) && o_tick |-> ext_q2_r && !ext_q3_r)
    else $error("tick without external edge");
  div_one_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (i_div_sel == 3'h0) |-> o_tick)
    else $error("divide by one missed a tick");
endmodule

//--- serial_rx_pkg.sv
// shared constants for the async serial receive-status block
package serial_rx_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] STATUS_OFF  = 8'h04;
  localparam logic [7:0] DATA_OFF    = 8'h08;
  localparam logic [7:0] INT_ST_OFF  = 8'h0c;
  localparam logic [7:0] INT_MSK_OFF = 8'h10;
  // control field positions
  localparam int DIV_SEL_LSB   = 0;
  localparam int DIV_SEL_W     = 3;
  localparam int RX_EN_BIT     = 3;
  localparam int DMA_EN_BIT    = 4;
  localparam int RIE_BIT       = 5;
  localparam int INHIBIT_BIT   = 7;
  localparam logic [2:0] DIV_EXT = 3'h7;
  // status bit positions
  localparam int READY_BIT   = 0;
  localparam int PAR_ERR_BIT = 1;
  localparam int FRM_ERR_BIT = 2;
  localparam int OVR_BIT     = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  // receive fifo
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;
  // serial frame: 16 serial clocks per bit, 8 data bits
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- serial_tx_model.sv
// behavioural remote transmitter driving the serial receive line
`timescale 1ns/100ps
module serial_tx_model
(
  // clock
  input  wire logic        i_sys_clk,
  // frame request
  input  wire logic        i_go,
  input  wire logic [7:0]  i_byte,
  input  wire logic [15:0] i_bit_cycles,
  input  wire logic        i_bad_parity,
  input  wire logic        i_bad_stop,
  // line
  output logic             o_txd,
  output logic             o_busy
);
  logic [10:0] frame;

  // line idles high between frames
  initial
  begin
    o_txd = 1'b1;
    o_busy = 1'b0;
  end

  // start, 8 data lsb first, even parity, stop; faults only on request
  always @(posedge i_sys_clk)
    if (i_go && !o_busy)
    begin
      frame = {~i_bad_stop, ^i_byte ^ i_bad_parity, i_byte, 1'b0};
      o_busy <= 1'b1;
      for (int k = 0; k < 11; k++)
      begin
        o_txd <= frame[k];
        repeat (i_bit_cycles) @(posedge i_sys_clk);
      end
      o_txd <= 1'b1;
      o_busy <= 1'b0;
    end
endmodule
